// ===== ldo_four_pkg.sv
// Constants for the fourth regulator control register set.
`default_nettype none
package ldo_four_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 16;
	localparam int          CODE_W           = 5;
	localparam int          SLOT_W           = 4;
	localparam int          MV_W             = 12;
	localparam logic [7:0]  MODE_VOLT_ADDR   = 8'hD1;
	localparam logic [7:0]  FAULT_SLOT_ADDR  = 8'hD2;
	localparam logic [7:0]  HIB_ADDR         = 8'hD3;
	localparam int          SWITCH_BIT       = 14;
	localparam int          FLOAT_BIT        = 10;
	localparam int          VSEL_LSB         = 0;
	localparam int          REACT_LSB        = 14;
	localparam int          START_LSB        = 10;
	localparam int          STOP_LSB         = 6;
	localparam int          HIB_MODE_LSB     = 12;
	localparam int          HIB_SRC_LSB      = 8;
	localparam int          VIMG_LSB         = 0;
	localparam int          NUM_LDO          = 4;
	localparam logic [4:0]  VSEL_RESET       = 5'h1B;
	localparam logic [4:0]  VIMG_RESET       = 5'h1C;
	localparam logic [3:0]  START_RESET      = 4'h0;
	localparam logic [3:0]  STOP_RESET       = 4'h0;
	localparam logic [3:0]  SLOT_NONE        = 4'h0;
	localparam logic [3:0]  SLOT_LAST_STATE  = 4'hF;
	localparam logic [1:0]  HIB_MODE_RESET   = 2'h0;
	localparam logic [1:0]  HIB_SRC_RESET    = 2'h0;
	localparam logic [11:0] LOW_BASE_MV      = 12'h384;
	localparam logic [11:0] LOW_STEP_MV      = 12'h032;
	localparam logic [11:0] HIGH_BASE_MV     = 12'h708;
	localparam logic [11:0] HIGH_STEP_MV     = 12'h064;
	typedef enum logic [1:0] {
		REACT_IGNORE   = 2'b00,
		REACT_REG_OFF  = 2'b01,
		REACT_SYS_OFF  = 2'b10,
		REACT_SYS_OFF2 = 2'b11
	} fault_reaction_e;
	typedef enum logic [1:0] {
		HIB_IMAGE    = 2'b00,
		HIB_DISABLE  = 2'b01,
		HIB_RSVD_A   = 2'b10,
		HIB_RSVD_B   = 2'b11
	} hibernate_behaviour_e;
	typedef enum logic [1:0] {
		SRC_REG_BIT  = 2'b00,
		SRC_LINE_ONE = 2'b01,
		SRC_LINE_TWO = 2'b10,
		SRC_LINE_THR = 2'b11
	} hibernate_source_e;
endpackage
`default_nettype wire

// ===== voltage_code_if.sv
// Carrier between the register set and a voltage code decoder.
`timescale 1ns/10ps
`default_nettype none
interface voltage_code_if;
	import ldo_four_pkg::*;
	logic [CODE_W-1:0] code;
	logic [MV_W-1:0]   millivolts;
	modport owner (output code, input millivolts);
	modport decoder (input code, output millivolts);
endinterface
`default_nettype wire

// ===== voltage_code_decode.sv
// Turns a five-bit regulator voltage code into millivolts.
`timescale 1ns/10ps
`default_nettype none
module voltage_code_decode (
	voltage_code_if.decoder port_if
);
	import ldo_four_pkg::*;
	logic [MV_W-1:0] step_count;

	// Lower half steps by 50 mV from 0.9 V, upper half by 100 mV from 1.8 V.
	always_comb begin
		step_count = {{(MV_W-CODE_W+1){1'b0}}, port_if.code[CODE_W-2:0]};
		if (port_if.code[CODE_W-1]) begin
			port_if.millivolts = MV_W'(HIGH_BASE_MV + step_count * HIGH_STEP_MV);
		end else begin
			port_if.millivolts = MV_W'(LOW_BASE_MV + step_count * LOW_STEP_MV);
		end
	end
endmodule // voltage_code_decode
`default_nettype wire

// ===== ldo_four_regs.sv
// Control and status register set of the fourth low-dropout regulator.
`timescale 1ns/10ps
`default_nettype none
module ldo_four_regs #(
	parameter logic [4:0] VSEL_DEFAULT  = ldo_four_pkg::VSEL_RESET,
	parameter logic [3:0] START_DEFAULT = ldo_four_pkg::START_RESET
) (
	input  wire logic                              clk_in,
	input  wire logic                              srst_in,
	input  wire logic                              sm_reset_in,
	input  wire logic                              reg_write_in,
	input  wire logic [ldo_four_pkg::ADDR_W-1:0]   reg_addr_in,
	input  wire logic [ldo_four_pkg::DATA_W-1:0]   reg_wdata_in,
	output logic      [ldo_four_pkg::DATA_W-1:0]   reg_rdata_out,
	input  wire logic                              fault_in,
	input  wire logic [ldo_four_pkg::NUM_LDO-1:0]  ldo_enabled_in,
	input  wire logic [ldo_four_pkg::SLOT_W-1:0]   seq_slot_in,
	input  wire logic                              seq_up_strobe_in,
	input  wire logic                              seq_down_strobe_in,
	input  wire logic                              enter_active_in,
	input  wire logic                              enter_off_in,
	input  wire logic                              hibernate_reg_bit_in,
	input  wire logic                              low_power_line_one_in,
	input  wire logic                              low_power_line_two_in,
	input  wire logic                              low_power_line_three_in,
	output logic                                   switch_mode_select_out,
	output logic                                   output_float_on_disable_out,
	output logic      [ldo_four_pkg::CODE_W-1:0]   output_voltage_code_out,
	output logic      [1:0]                        fault_reaction_out,
	output logic      [ldo_four_pkg::SLOT_W-1:0]   startup_slot_out,
	output logic      [ldo_four_pkg::SLOT_W-1:0]   shutdown_slot_out,
	output logic      [1:0]                        hibernate_behaviour_out,
	output logic      [1:0]                        hibernate_source_select_out,
	output logic      [ldo_four_pkg::CODE_W-1:0]   hibernate_voltage_code_out,
	output logic                                   discharge_out,
	output logic                                   fault_irq_out,
	output logic                                   shutdown_regulator_out,
	output logic                                   shutdown_system_out,
	output logic                                   startup_now_out,
	output logic                                   shutdown_now_out,
	output logic                                   hibernate_active_out,
	output logic                                   regulating_out,
	output logic      [ldo_four_pkg::MV_W-1:0]     target_mv_out
);
	import ldo_four_pkg::*;

	voltage_code_if normal_if ();
	voltage_code_if image_if ();

	voltage_code_decode normal_dec (
		.port_if (normal_if.decoder)
	);
	voltage_code_decode image_dec (
		.port_if (image_if.decoder)
	);

	logic                       switch_reg, switch_next;
	logic                       float_reg, float_next;
	logic [CODE_W-1:0]          vsel_reg, vsel_next;
	fault_reaction_e            react_reg, react_next;
	logic [SLOT_W-1:0]          start_reg, start_next;
	logic [SLOT_W-1:0]          stop_reg, stop_next;
	hibernate_behaviour_e       hmode_reg, hmode_next;
	hibernate_source_e          hsrc_reg, hsrc_next;
	logic [CODE_W-1:0]          vimg_reg, vimg_next;
	logic [DATA_W-1:0]          rdata_reg, rdata_next;
	logic [2:0]                 line_s1_reg, line_s2_reg, line_s3_reg;
	logic [2:0]                 line_reg, line_next;
	logic                       hib_sel;
	logic                       discharge_reg, discharge_next;
	logic                       irq_reg, irq_next;
	logic                       sd_reg_reg, sd_reg_next;
	logic                       sd_sys_reg, sd_sys_next;
	logic                       start_now_reg, start_now_next;
	logic                       stop_now_reg, stop_now_next;
	logic                       hib_reg, hib_next;
	logic                       regulating_reg, regulating_next;
	logic [MV_W-1:0]            mv_reg, mv_next;

	assign normal_if.code = vsel_reg;
	assign image_if.code  = vimg_reg;

	// Register fields: either reset source reloads the variant defaults on the next clock edge.
	always_comb begin
		switch_next = switch_reg;
		float_next  = float_reg;
		vsel_next   = vsel_reg;
		react_next  = react_reg;
		start_next  = start_reg;
		stop_next   = stop_reg;
		hmode_next  = hmode_reg;
		hsrc_next   = hsrc_reg;
		vimg_next   = vimg_reg;
		if (sm_reset_in) begin
			switch_next = 1'b0;
			float_next  = 1'b0;
			vsel_next   = VSEL_DEFAULT;
			react_next  = REACT_IGNORE;
			start_next  = START_DEFAULT;
			stop_next   = STOP_RESET;
			hmode_next  = hibernate_behaviour_e'(HIB_MODE_RESET);
			hsrc_next   = hibernate_source_e'(HIB_SRC_RESET);
			vimg_next   = VIMG_RESET;
		end else if (reg_write_in) begin
			case (reg_addr_in)
				MODE_VOLT_ADDR: begin
					switch_next = reg_wdata_in[SWITCH_BIT];
					float_next  = reg_wdata_in[FLOAT_BIT];
					vsel_next   = reg_wdata_in[VSEL_LSB +: CODE_W];
				end
				FAULT_SLOT_ADDR: begin
					react_next = fault_reaction_e'(reg_wdata_in[REACT_LSB +: 2]);
					start_next = reg_wdata_in[START_LSB +: SLOT_W];
					stop_next  = reg_wdata_in[STOP_LSB +: SLOT_W];
				end
				HIB_ADDR: begin
					hmode_next = hibernate_behaviour_e'(reg_wdata_in[HIB_MODE_LSB +: 2]);
					hsrc_next  = hibernate_source_e'(reg_wdata_in[HIB_SRC_LSB +: 2]);
					vimg_next  = reg_wdata_in[VIMG_LSB +: CODE_W];
				end
				default: begin
					switch_next = switch_reg;
				end
			endcase
		end
	end

	// Read data is registered, so it appears one cycle after the address; other addresses read zero.
	always_comb begin
		rdata_next = '0;
		case (reg_addr_in)
			MODE_VOLT_ADDR: begin
				rdata_next[SWITCH_BIT]             = switch_reg;
				rdata_next[FLOAT_BIT]              = float_reg;
				rdata_next[VSEL_LSB +: CODE_W]     = vsel_reg;
			end
			FAULT_SLOT_ADDR: begin
				rdata_next[REACT_LSB +: 2]         = react_reg;
				rdata_next[START_LSB +: SLOT_W]    = start_reg;
				rdata_next[STOP_LSB +: SLOT_W]     = stop_reg;
			end
			HIB_ADDR: begin
				rdata_next[HIB_MODE_LSB +: 2]      = hmode_reg;
				rdata_next[HIB_SRC_LSB +: 2]       = hsrc_reg;
				rdata_next[VIMG_LSB +: CODE_W]     = vimg_reg;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// Low-power lines are asynchronous pins; a level is taken only once stages two and three agree.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			line_next[i] = (line_s2_reg[i] == line_s3_reg[i]) ? line_s3_reg[i] : line_reg[i];
		end
	end

	always_comb begin
		case (hsrc_reg)
			SRC_REG_BIT:  hib_sel = hibernate_reg_bit_in;
			SRC_LINE_ONE: hib_sel = line_reg[0];
			SRC_LINE_TWO: hib_sel = line_reg[1];
			SRC_LINE_THR: hib_sel = line_reg[2];
			default:      hib_sel = 1'b0;
		endcase
	end

	// Derived controls for the sequencer and the analogue stage.
	always_comb begin
		hib_next = hib_sel;
		// The all-off case must win over the float bit so no rail is left charged.
		discharge_next = (~|ldo_enabled_in) | (~ldo_enabled_in[NUM_LDO-1] & ~float_reg);
		irq_next    = fault_in;
		sd_reg_next = fault_in & (react_reg == REACT_REG_OFF);
		sd_sys_next = fault_in & react_reg[1];
		start_now_next = ((start_reg != SLOT_NONE) & (start_reg != SLOT_LAST_STATE) &
			seq_up_strobe_in & (seq_slot_in == start_reg)) |
			((start_reg == SLOT_LAST_STATE) & enter_active_in);
		stop_now_next = ((stop_reg != SLOT_NONE) & (stop_reg != SLOT_LAST_STATE) &
			seq_down_strobe_in & (seq_slot_in == stop_reg)) |
			(((stop_reg == SLOT_NONE) | (stop_reg == SLOT_LAST_STATE)) & enter_off_in);
		regulating_next = ~switch_reg & ~(hib_sel & (hmode_reg == HIB_DISABLE));
		if (switch_reg) begin
			mv_next = '0;
		end else if (hib_sel & (hmode_reg == HIB_IMAGE)) begin
			mv_next = image_if.millivolts;
		end else if (hib_sel & (hmode_reg == HIB_DISABLE)) begin
			mv_next = '0;
		end else begin
			mv_next = normal_if.millivolts;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			switch_reg     <= 1'b0;
			float_reg      <= 1'b0;
			vsel_reg       <= VSEL_DEFAULT;
			react_reg      <= REACT_IGNORE;
			start_reg      <= START_DEFAULT;
			stop_reg       <= STOP_RESET;
			hmode_reg      <= hibernate_behaviour_e'(HIB_MODE_RESET);
			hsrc_reg       <= hibernate_source_e'(HIB_SRC_RESET);
			vimg_reg       <= VIMG_RESET;
			rdata_reg      <= '0;
			line_s1_reg    <= '0;
			line_s2_reg    <= '0;
			line_s3_reg    <= '0;
			line_reg       <= '0;
			discharge_reg  <= 1'b0;
			irq_reg        <= 1'b0;
			sd_reg_reg     <= 1'b0;
			sd_sys_reg     <= 1'b0;
			start_now_reg  <= 1'b0;
			stop_now_reg   <= 1'b0;
			hib_reg        <= 1'b0;
			regulating_reg <= 1'b0;
			mv_reg         <= '0;
		end else begin
			switch_reg     <= switch_next;
			float_reg      <= float_next;
			vsel_reg       <= vsel_next;
			react_reg      <= react_next;
			start_reg      <= start_next;
			stop_reg       <= stop_next;
			hmode_reg      <= hmode_next;
			hsrc_reg       <= hsrc_next;
			vimg_reg       <= vimg_next;
			rdata_reg      <= rdata_next;
			line_s1_reg    <= {low_power_line_three_in, low_power_line_two_in, low_power_line_one_in};
			line_s2_reg    <= line_s1_reg;
			line_s3_reg    <= line_s2_reg;
			line_reg       <= line_next;
			discharge_reg  <= discharge_next;
			irq_reg        <= irq_next;
			sd_reg_reg     <= sd_reg_next;
			sd_sys_reg     <= sd_sys_next;
			start_now_reg  <= start_now_next;
			stop_now_reg   <= stop_now_next;
			hib_reg        <= hib_next;
			regulating_reg <= regulating_next;
			mv_reg         <= mv_next;
		end
	end

	assign reg_rdata_out               = rdata_reg;
	assign switch_mode_select_out      = switch_reg;
	assign output_float_on_disable_out = float_reg;
	assign output_voltage_code_out     = vsel_reg;
	assign fault_reaction_out          = react_reg;
	assign startup_slot_out            = start_reg;
	assign shutdown_slot_out           = stop_reg;
	assign hibernate_behaviour_out     = hmode_reg;
	assign hibernate_source_select_out = hsrc_reg;
	assign hibernate_voltage_code_out  = vimg_reg;
	assign discharge_out               = discharge_reg;
	assign fault_irq_out               = irq_reg;
	assign shutdown_regulator_out      = sd_reg_reg;
	assign shutdown_system_out         = sd_sys_reg;
	assign startup_now_out             = start_now_reg;
	assign shutdown_now_out            = stop_now_reg;
	assign hibernate_active_out        = hib_reg;
	assign regulating_out              = regulating_reg;
	assign target_mv_out               = mv_reg;
endmodule // ldo_four_regs
`default_nettype wire

// ===== ldo_four_regs_chk.sv
// Concurrent checks on the ports of the fourth regulator register set.
`timescale 1ns/10ps
`default_nettype none
module ldo_four_regs_chk #(
	parameter logic [4:0] VSEL_DEFAULT = 5'h1B
) (
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic        sm_reset_in,
	input wire logic        fault_in,
	input wire logic [3:0]  ldo_enabled_in,
	input wire logic [3:0]  seq_slot_in,
	input wire logic        seq_up_strobe_in,
	input wire logic        enter_off_in,
	input wire logic        switch_mode_select_out,
	input wire logic        output_float_on_disable_out,
	input wire logic [4:0]  output_voltage_code_out,
	input wire logic [1:0]  fault_reaction_out,
	input wire logic [3:0]  startup_slot_out,
	input wire logic [3:0]  shutdown_slot_out,
	input wire logic [4:0]  hibernate_voltage_code_out,
	input wire logic        discharge_out,
	input wire logic        fault_irq_out,
	input wire logic        shutdown_regulator_out,
	input wire logic        shutdown_system_out,
	input wire logic        startup_now_out,
	input wire logic        shutdown_now_out,
	input wire logic        regulating_out,
	input wire logic [11:0] target_mv_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence fault_seen;
		fault_in && !srst_in;
	endsequence
	sequence up_match;
		seq_up_strobe_in && seq_slot_in == startup_slot_out && startup_slot_out != 4'h0 && startup_slot_out != 4'hF;
	endsequence
	fault_irq_a: assert property (fault_seen |=> fault_irq_out)
		else $error("fault gave no interrupt");
	reg_off_a: assert property (fault_seen ##0 fault_reaction_out == 2'h1
		|=> shutdown_regulator_out && !shutdown_system_out)
		else $error("regulator shutdown missing");
	sys_off_a: assert property (fault_seen ##0 fault_reaction_out[1]
		|=> shutdown_system_out && !shutdown_regulator_out)
		else $error("system shutdown missing");
	quiet_a: assert property (!fault_in |=> !fault_irq_out && !shutdown_system_out && !shutdown_regulator_out)
		else $error("fault reaction without fault");
	all_off_a: assert property (ldo_enabled_in == 4'h0 |=> discharge_out)
		else $error("outputs not discharged with all off");
	float_keep_a: assert property (!ldo_enabled_in[3] && ldo_enabled_in != 4'h0
		|=> discharge_out == !$past(output_float_on_disable_out))
		else $error("discharge disagrees with float bit");
	start_slot_a: assert property (up_match |=> startup_now_out)
		else $error("start-up slot missed");
	start_never_a: assert property (startup_slot_out == 4'h0 |=> !startup_now_out)
		else $error("disabled regulator started");
	off_entry_a: assert property (enter_off_in && (shutdown_slot_out == 4'h0 || shutdown_slot_out == 4'hF)
		|=> shutdown_now_out)
		else $error("shutdown on off entry missed");
	sm_defaults_a: assert property (sm_reset_in
		|=> !switch_mode_select_out && !output_float_on_disable_out && fault_reaction_out == 2'h0
		&& output_voltage_code_out == VSEL_DEFAULT && hibernate_voltage_code_out == 5'h1C)
		else $error("state machine reset left a field");
	switch_a: assert property (switch_mode_select_out |=> !regulating_out && target_mv_out == 12'h000)
		else $error("switch mode still regulates");
endmodule // ldo_four_regs_chk
`default_nettype wire

// ===== ldo_four_regs_test.sv
// Self-checking bench for the fourth regulator register set.
`timescale 1ns/10ps
`default_nettype none
module ldo_four_regs_test;
	import ldo_four_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        smr = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wd = 16'h0000;
	logic [3:0]  en = 4'hF;
	logic [3:0]  slot = 4'h0;
	logic [4:0]  strb = 5'h00;
	logic        hb = 1'b0;
	logic [2:0]  lp = 3'h0;
	logic [15:0] rd;
	logic        sw, flt, dis, irq, sreg, ssys, son, sdn, hact, regu;
	logic [4:0]  vc;
	logic [1:0]  ra, hbo, hso;
	logic [3:0]  sso, sdo;
	logic [4:0]  hvc;
	logic [11:0] mv;
	int          bad_count = 0;
	int          checked = 0;
	int          cycles = 0;
	always #50 clk = ~clk;
	ldo_four_regs uut (.clk_in(clk), .srst_in(srst), .sm_reset_in(smr), .reg_write_in(we), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_rdata_out(rd), .fault_in(strb[0]), .ldo_enabled_in(en), .seq_slot_in(slot),
		.seq_up_strobe_in(strb[1]), .seq_down_strobe_in(strb[2]), .enter_active_in(strb[3]),
		.enter_off_in(strb[4]), .hibernate_reg_bit_in(hb), .low_power_line_one_in(lp[0]),
		.low_power_line_two_in(lp[1]), .low_power_line_three_in(lp[2]), .switch_mode_select_out(sw),
		.output_float_on_disable_out(flt), .output_voltage_code_out(vc), .fault_reaction_out(ra),
		.startup_slot_out(sso), .shutdown_slot_out(sdo), .hibernate_behaviour_out(hbo), .hibernate_source_select_out(hso),
		.hibernate_voltage_code_out(hvc), .discharge_out(dis), .fault_irq_out(irq), .shutdown_regulator_out(sreg),
		.shutdown_system_out(ssys), .startup_now_out(son), .shutdown_now_out(sdn), .hibernate_active_out(hact),
		.regulating_out(regu), .target_mv_out(mv));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr = a;
		wd = d;
		we = 1'b1;
		cyc(1);
		we = 1'b0;
	endtask
	task automatic rdck(input logic [7:0] a, input logic [15:0] e, input string nm);
		addr = a;
		cyc(1);
		chk(nm, e, rd);
	endtask
	// Strobes stay up until the next call replaces them, and step(5'h00) clears them; one-hot values set no two signals at once.
	task automatic step(input logic [4:0] s);
		strb = s;
		cyc(1);
	endtask
	function automatic logic [15:0] volts(input int c);
		return (c < 16) ? 16'(900 + 50 * c) : 16'(1800 + 100 * (c - 16));
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		cyc(5);
		srst = 1'b0;
		rdck(MODE_VOLT_ADDR, 16'h001B, "ctrl reset");
		rdck(FAULT_SLOT_ADDR, 16'h0000, "slot reset");
		rdck(HIB_ADDR, 16'h001C, "hib reset");
		wr(MODE_VOLT_ADDR, 16'hFFFF);
		rdck(MODE_VOLT_ADDR, 16'h441F, "ctrl bits");
		chk("ctrl fields", 16'h007F, {9'h000, sw, flt, vc});
		chk("switch mv", 16'h0000, 16'(mv));
		chk("switch reg", 16'h0000, 16'(regu));
		en = 4'h7;
		cyc(1);
		chk("float kept", 16'h0000, 16'(dis));
		en = 4'h0;
		cyc(1);
		chk("all off", 16'h0001, 16'(dis));
		wr(MODE_VOLT_ADDR, 16'h0000);
		en = 4'h7;
		cyc(1);
		chk("discharge", 16'h0001, 16'(dis));
		en = 4'hF;
		for (int c = 0; c < 32; c++) begin
			wr(MODE_VOLT_ADDR, 16'(c));
			cyc(1);
			chk("target mv", volts(c), 16'(mv));
		end
		for (int r = 0; r < 4; r++) begin
			wr(FAULT_SLOT_ADDR, 16'(r << 14));
			step(5'h01);
			chk("fault react", {13'h0, 1'b1, r == 1, r >= 2}, {13'h0, irq, sreg, ssys});
			step(5'h00);
		end
		for (int s = 0; s < 16; s++) begin
			wr(FAULT_SLOT_ADDR, 16'((s << 10) | (s << 6)));
			slot = 4'(s);
			step(5'h02);
			chk("start slot", 16'(s > 0 && s < 15), 16'(son));
			step(5'h08);
			chk("start active", 16'(s == 15), 16'(son));
			step(5'h04);
			chk("stop slot", 16'(s > 0 && s < 15), 16'(sdn));
			step(5'h10);
			chk("stop off", 16'(s == 0 || s == 15), 16'(sdn));
			slot = 4'(s + 1);
			step(5'h02);
			chk("other slot", 16'h0000, 16'(son));
			step(5'h00);
		end
		// The low-power lines pass a three-stage synchroniser, so six cycles are allowed.
		for (int h = 0; h < 4; h++) begin
			wr(HIB_ADDR, 16'((h << 8) | 5));
			{lp, hb} = 4'(1 << h);
			cyc(6);
			chk("hib image", volts(5), 16'(mv));
			chk("hib active", 16'h0001, 16'(hact));
		end
		{lp, hb} = 4'h1;
		for (int b = 1; b < 4; b++) begin
			wr(HIB_ADDR, 16'((b << 12) | 5));
			cyc(1);
			chk("hib mv", (b == 1) ? 16'h0000 : volts(31), 16'(mv));
			chk("hib reg", 16'(b != 1), 16'(regu));
		end
		wr(HIB_ADDR, 16'hFFFF);
		rdck(HIB_ADDR, 16'h331F, "hib bits");
		chk("hib fields", 16'h01FF, {7'h00, hbo, hso, hvc});
		wr(FAULT_SLOT_ADDR, 16'hFFFF);
		rdck(FAULT_SLOT_ADDR, 16'hFFC0, "slot bits");
		chk("slot fields", 16'h03FF, {6'h00, ra, sso, sdo});
		wr(8'hD4, 16'hFFFF);
		rdck(8'hD4, 16'h0000, "unmapped");
		smr = 1'b1;
		wr(MODE_VOLT_ADDR, 16'h4400);
		smr = 1'b0;
		rdck(MODE_VOLT_ADDR, 16'h001B, "sm ctrl");
		rdck(FAULT_SLOT_ADDR, 16'h0000, "sm slot");
		rdck(HIB_ADDR, 16'h001C, "sm hib");
		chk("sm ctrl fields", 16'h001B, {9'h000, sw, flt, vc});
		chk("sm slot fields", 16'h0000, {6'h00, ra, sso, sdo});
		chk("sm hib fields", 16'h001C, {7'h00, hbo, hso, hvc});
		final_report();
	end
endmodule // ldo_four_regs_test
bind ldo_four_regs ldo_four_regs_chk #(.VSEL_DEFAULT(VSEL_DEFAULT)) chk_i (.clk_in(clk_in), .srst_in(srst_in),
	.sm_reset_in(sm_reset_in), .fault_in(fault_in), .ldo_enabled_in(ldo_enabled_in), .seq_slot_in(seq_slot_in),
	.seq_up_strobe_in(seq_up_strobe_in), .enter_off_in(enter_off_in), .switch_mode_select_out(switch_mode_select_out),
	.output_float_on_disable_out(output_float_on_disable_out), .output_voltage_code_out(output_voltage_code_out),
	.fault_reaction_out(fault_reaction_out), .startup_slot_out(startup_slot_out),
	.shutdown_slot_out(shutdown_slot_out), .hibernate_voltage_code_out(hibernate_voltage_code_out),
	.discharge_out(discharge_out), .fault_irq_out(fault_irq_out), .shutdown_regulator_out(shutdown_regulator_out),
	.shutdown_system_out(shutdown_system_out), .startup_now_out(startup_now_out),
	.shutdown_now_out(shutdown_now_out), .regulating_out(regulating_out), .target_mv_out(target_mv_out));
`default_nettype wire
